// ===== pkg/lpm_pkg.sv
// shared constants and types for the lcd power mode control link
package lpm_pkg;
	// command byte decode
	localparam logic [3:0] LPM_CONTRAST_OP = 4'h7;
	localparam logic [4:0] LPM_POWER_CTRL_OP = 5'h0A;
	localparam logic [3:0] LPM_POWER_SAVE_OP = 4'h4;
	localparam logic [3:0] LPM_DISPLAY_OP = 4'h3;
	// field positions
	localparam int LPM_REG_BIT = 2;
	localparam int LPM_FOL_BIT = 1;
	localparam int LPM_BOOST_BIT = 0;
	localparam int LPM_OSC_BIT = 1;
	localparam int LPM_SAVE_BIT = 0;
	localparam int LPM_CUR_BIT = 3;
	localparam int LPM_BLINK_BIT = 2;
	localparam int LPM_DUAL_BIT = 1;
	localparam int LPM_DISP_BIT = 0;
	localparam int LPM_SYSSET_BIT = 3;
	// reset values
	localparam logic [3:0] LPM_CONTRAST_RST = 4'h0;
	localparam logic [3:0] LPM_CONTRAST_MID = 4'h8;
	// timing
	localparam int LPM_CLK_NS = 50;
	localparam int LPM_RST_HOLD_NS = 10000;
	localparam int LPM_RST_HOLD_CYC = (LPM_RST_HOLD_NS + LPM_CLK_NS - 1) / LPM_CLK_NS;
	localparam int LPM_START_NS = 1000;
	localparam int LPM_START_CYC = LPM_START_NS / LPM_CLK_NS;
	localparam int LPM_SETTLE_CYC = 4;
	localparam int LPM_CNT_W = 9;
	// host registers (AXI4-Lite byte addresses)
	localparam logic [3:0] LPM_A_CMD = 4'h0;
	localparam logic [3:0] LPM_A_DATA = 4'h4;
	localparam logic [3:0] LPM_A_STAT = 4'h8;
	localparam logic [3:0] LPM_A_LINK = 4'hC;
	localparam logic [1:0] LPM_RESP_OK = 2'h0;
	localparam logic [1:0] LPM_RESP_ERR = 2'h2;
endpackage

// ===== pkg/lpm_link_if.sv
// link between host end and lcd power mode device end
`timescale 1ns/100ps
interface lpm_link_if;
	logic chip_reset_in;
	logic wr_stb;
	logic register_select;
	logic [7:0] wr_data;
	modport host (output chip_reset_in, output wr_stb, output register_select, output wr_data);
	modport dev (input chip_reset_in, input wr_stb, input register_select, input wr_data);
endinterface

// ===== design/lpm_device.sv
// device end: command decode, power state, sleep and reset defaults
// Behaviour
// - keep 4-bit contrast code, drive regulator
// - contrast cleared on reset, writable zero
// - sleep only with power stages off
// - sleep holds all drive outputs high
// - sleep leaves display memories untouched
// - sleep stops circuits, retains prior state
// - reset clears display, oscillator, save, glyph-use
// - reset turns regulator, follower, boost off
// - host holds reset at least 10 us
// - operation begins within 1 us after release
// - boost needs oscillator running
// - reset held while external supply switches
// - host preloads contrast 1000 or 0111 (lpm_host sends no preload; reset leaves contrast 0000)
// - select low is command, high is data
// - bytes 70h-7Fh load contrast code
// - power command sets regulator, follower, boost
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module lpm_device (
	// clock
	input wire logic I_REF_CLK,
	// link
	lpm_link_if.dev link,
	// user side: system-set input for glyph ram use
	input wire logic i_glyph_use_req,
	// state outputs
	output logic [3:0] O_CONTRAST,
	output logic O_REGULATOR_ENABLE,
	output logic O_FOLLOWER_ENABLE,
	output logic O_BOOST_ENABLE,
	output logic O_OSC_ON,
	output logic O_POWER_SAVE_FLAG,
	output logic O_SLEEP,
	output logic O_DISPLAY_ON,
	output logic O_CURSOR_SHOW,
	output logic O_BLINK,
	output logic O_DUAL_CURSOR,
	output logic O_USER_GLYPH_RAM_USE,
	output logic O_COMMON_DRIVE_HIGH,
	output logic O_SEGMENT_DRIVE_HIGH,
	output logic O_DATA_STB,
	output logic [7:0] O_DATA,
	output logic O_READY
);
	// contrast and power stage state
	logic [3:0] contrast_reg;
	logic [3:0] contrast_next;
	logic reg_en_reg;
	logic reg_en_next;
	logic fol_en_reg;
	logic fol_en_next;
	logic boost_reg;
	logic boost_next;
	// oscillator, save and sleep state
	logic osc_reg;
	logic osc_next;
	logic save_reg;
	logic save_next;
	logic sleep_reg;
	logic sleep_next;
	// display control and glyph use
	logic disp_reg;
	logic disp_next;
	logic cur_reg;
	logic cur_next;
	logic blink_reg;
	logic blink_next;
	logic dual_reg;
	logic dual_next;
	logic glyph_reg;
	logic glyph_next;
	// startup window and output stage
	logic [lpm_pkg::LPM_CNT_W-1:0] start_cnt_reg;
	logic [lpm_pkg::LPM_CNT_W-1:0] start_cnt_next;
	logic ready_reg;
	logic ready_next;
	logic drive_hi_reg;
	logic drive_hi_next;
	logic data_stb_reg;
	logic data_stb_next;
	logic [7:0] data_reg;
	logic [7:0] data_next;

	// upper-nibble opcode match on a command byte
	function automatic logic op_hit4(input logic [7:0] byte_in, input logic [3:0] op);
		op_hit4 = (byte_in[7:4] == op);
	endfunction

	// link decode
	wire rst = link.chip_reset_in;
	wire cmd = link.wr_stb & ~link.register_select;
	wire dat = link.wr_stb & link.register_select;
	wire [7:0] b = link.wr_data;
	wire is_contrast = cmd & op_hit4(b, lpm_pkg::LPM_CONTRAST_OP);
	wire is_power = cmd & (b[7:3] == lpm_pkg::LPM_POWER_CTRL_OP);
	wire is_save = cmd & op_hit4(b, lpm_pkg::LPM_POWER_SAVE_OP) & ~b[lpm_pkg::LPM_SYSSET_BIT];
	wire is_disp = cmd & op_hit4(b, lpm_pkg::LPM_DISPLAY_OP);
	wire save_set = b[lpm_pkg::LPM_SAVE_BIT];
	wire osc_req = b[lpm_pkg::LPM_OSC_BIT];

	// sleep gating and power stage interlocks
	wire live = ~sleep_reg;
	wire stages_off = ~reg_en_reg & ~fol_en_reg & ~boost_reg;
	wire enter_sleep = is_save & save_set & ~osc_req & stages_off;
	wire osc_stop = is_save & ~osc_req;
	wire boost_cmd = b[lpm_pkg::LPM_BOOST_BIT] & osc_reg;
	wire take_contrast = is_contrast & live;
	wire take_power = is_power & live;
	wire take_disp = is_disp & live;
	wire take_data = dat & live;
	wire start_done = (start_cnt_reg == lpm_pkg::LPM_CNT_W'(lpm_pkg::LPM_START_CYC - 1));

	// next-state selection
	assign contrast_next = take_contrast ? b[3:0] : contrast_reg;
	assign reg_en_next = take_power ? b[lpm_pkg::LPM_REG_BIT] : reg_en_reg;
	assign fol_en_next = take_power ? b[lpm_pkg::LPM_FOL_BIT] : fol_en_reg;
	assign boost_next = take_power ? boost_cmd : (boost_reg & ~osc_stop);
	assign osc_next = is_save ? osc_req : osc_reg;
	assign save_next = is_save ? save_set : save_reg;
	assign sleep_next = is_save ? enter_sleep : sleep_reg;
	assign disp_next = take_disp ? b[lpm_pkg::LPM_DISP_BIT] : disp_reg;
	assign cur_next = take_disp ? b[lpm_pkg::LPM_CUR_BIT] : cur_reg;
	assign blink_next = take_disp ? b[lpm_pkg::LPM_BLINK_BIT] : blink_reg;
	assign dual_next = take_disp ? b[lpm_pkg::LPM_DUAL_BIT] : dual_reg;
	assign glyph_next = glyph_reg | (i_glyph_use_req & live);
	assign start_cnt_next = ready_reg ? start_cnt_reg : start_cnt_reg + 1'b1;
	assign ready_next = ready_reg | start_done;
	assign drive_hi_next = sleep_reg;
	assign data_stb_next = take_data;
	assign data_next = take_data ? b : data_reg;

	// contrast and power stages, async reset
	always_ff @(posedge I_REF_CLK or posedge rst) begin
		if (rst) begin
			contrast_reg <= lpm_pkg::LPM_CONTRAST_RST;
			reg_en_reg <= 1'b0;
			fol_en_reg <= 1'b0;
			boost_reg <= 1'b0;
		end else begin
			contrast_reg <= contrast_next;
			reg_en_reg <= reg_en_next;
			fol_en_reg <= fol_en_next;
			boost_reg <= boost_next;
		end
	end

	// oscillator, sleep and display flags, async reset
	always_ff @(posedge I_REF_CLK or posedge rst) begin
		if (rst) begin
			osc_reg <= 1'b0;
			save_reg <= 1'b0;
			sleep_reg <= 1'b0;
			disp_reg <= 1'b0;
			cur_reg <= 1'b0;
			blink_reg <= 1'b0;
			dual_reg <= 1'b0;
			glyph_reg <= 1'b0;
		end else begin
			osc_reg <= osc_next;
			save_reg <= save_next;
			sleep_reg <= sleep_next;
			disp_reg <= disp_next;
			cur_reg <= cur_next;
			blink_reg <= blink_next;
			dual_reg <= dual_next;
			glyph_reg <= glyph_next;
		end
	end

	// startup window and output stage, async reset
	always_ff @(posedge I_REF_CLK or posedge rst) begin
		if (rst) begin
			start_cnt_reg <= '0;
			ready_reg <= 1'b0;
			drive_hi_reg <= 1'b0;
			data_stb_reg <= 1'b0;
			data_reg <= 8'h00;
		end else begin
			start_cnt_reg <= start_cnt_next;
			ready_reg <= ready_next;
			drive_hi_reg <= drive_hi_next;
			data_stb_reg <= data_stb_next;
			data_reg <= data_next;
		end
	end

	// outputs straight from registers
	assign O_CONTRAST = contrast_reg;
	assign O_REGULATOR_ENABLE = reg_en_reg;
	assign O_FOLLOWER_ENABLE = fol_en_reg;
	assign O_BOOST_ENABLE = boost_reg;
	assign O_OSC_ON = osc_reg;
	assign O_POWER_SAVE_FLAG = save_reg;
	assign O_SLEEP = sleep_reg;
	assign O_DISPLAY_ON = disp_reg;
	assign O_CURSOR_SHOW = cur_reg;
	assign O_BLINK = blink_reg;
	assign O_DUAL_CURSOR = dual_reg;
	assign O_USER_GLYPH_RAM_USE = glyph_reg;
	assign O_COMMON_DRIVE_HIGH = drive_hi_reg;
	assign O_SEGMENT_DRIVE_HIGH = drive_hi_reg;
	assign O_DATA_STB = data_stb_reg;
	assign O_DATA = data_reg;
	assign O_READY = ready_reg;
endmodule

// ===== design/lpm_host.sv
// host end: AXI4-Lite registers drive command writes and reset on the link
`timescale 1ns/100ps
module lpm_host (
	// clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_RST,
	// link
	lpm_link_if.host link,
	// axi write address / data / response
	input wire logic [3:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	// axi read
	input wire logic [3:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready
);
	logic aw_got_reg, w_got_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [3:0] awaddr_reg;
	logic [7:0] wbyte_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic stb_reg, sel_reg, rst_out_reg;
	logic [7:0] wd_reg;
	logic [lpm_pkg::LPM_CNT_W-1:0] rst_cnt_reg;
	wire do_write = aw_got_reg & w_got_reg & ~bvalid_reg;
	wire wr_cmd = do_write & (awaddr_reg == lpm_pkg::LPM_A_CMD);
	wire wr_dat = do_write & (awaddr_reg == lpm_pkg::LPM_A_DATA);
	wire wr_link = do_write & (awaddr_reg == lpm_pkg::LPM_A_LINK);
	wire wr_ok = wr_cmd | wr_dat | wr_link;
	wire rst_busy = rst_out_reg | (rst_cnt_reg != '0);
	wire rd_ok = (i_araddr == lpm_pkg::LPM_A_STAT) | (i_araddr == lpm_pkg::LPM_A_LINK);
	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= 4'h0;
			wbyte_reg <= 8'h00;
			bvalid_reg <= 1'b0;
			bresp_reg <= lpm_pkg::LPM_RESP_OK;
			stb_reg <= 1'b0;
			sel_reg <= 1'b0;
			wd_reg <= 8'h00;
			rst_out_reg <= 1'b1;
			rst_cnt_reg <= lpm_pkg::LPM_CNT_W'(lpm_pkg::LPM_RST_HOLD_CYC);
		end else begin
			if (i_awvalid && !aw_got_reg && !bvalid_reg) begin
				aw_got_reg <= 1'b1;
				awaddr_reg <= i_awaddr;
			end
			if (i_wvalid && !w_got_reg && !bvalid_reg) begin
				w_got_reg <= 1'b1;
				wbyte_reg <= i_wdata[7:0];
			end
			stb_reg <= (wr_cmd | wr_dat) & ~rst_busy;
			if (do_write) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_ok ? lpm_pkg::LPM_RESP_OK : lpm_pkg::LPM_RESP_ERR;
				sel_reg <= wr_dat;
				wd_reg <= wbyte_reg;
			end else if (bvalid_reg && i_bready) begin
				bvalid_reg <= 1'b0;
			end
			if (wr_link && wbyte_reg[0]) begin
				rst_out_reg <= 1'b1;
				rst_cnt_reg <= lpm_pkg::LPM_CNT_W'(lpm_pkg::LPM_RST_HOLD_CYC);
			end else if (rst_cnt_reg != '0) begin
				rst_cnt_reg <= rst_cnt_reg - 1'b1;
			end else begin
				rst_out_reg <= 1'b0;
			end
		end
	end
	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= lpm_pkg::LPM_RESP_OK;
		end else begin
			arready_reg <= i_arvalid & ~arready_reg & ~rvalid_reg;
			if (arready_reg) begin
				rvalid_reg <= 1'b1;
				rresp_reg <= rd_ok ? lpm_pkg::LPM_RESP_OK : lpm_pkg::LPM_RESP_ERR;
				rdata_reg <= {30'h0, rst_busy, stb_reg | (aw_got_reg & w_got_reg)};
			end else if (rvalid_reg && i_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end
	assign o_awready = ~aw_got_reg & ~bvalid_reg;
	assign o_wready = ~w_got_reg & ~bvalid_reg;
	assign o_bvalid = bvalid_reg;
	assign o_bresp = bresp_reg;
	assign o_arready = arready_reg;
	assign o_rvalid = rvalid_reg;
	assign o_rdata = rdata_reg;
	assign o_rresp = rresp_reg;
	assign link.chip_reset_in = rst_out_reg;
	assign link.wr_stb = stb_reg;
	assign link.register_select = sel_reg;
	assign link.wr_data = wd_reg;
endmodule

// ===== sim/lpm_chk.sv
// assertions on the lcd power link and device state
`timescale 1ns/100ps
module lpm_chk (
	// clock and link
	input wire logic I_REF_CLK,
	input wire logic chip_reset_in,
	input wire logic wr_stb,
	input wire logic register_select,
	input wire logic [7:0] wr_data,
	// device state
	input wire logic [3:0] O_CONTRAST,
	input wire logic O_REGULATOR_ENABLE,
	input wire logic O_FOLLOWER_ENABLE,
	input wire logic O_BOOST_ENABLE,
	input wire logic O_OSC_ON,
	input wire logic O_SLEEP,
	input wire logic O_DISPLAY_ON,
	input wire logic O_COMMON_DRIVE_HIGH,
	input wire logic O_DATA_STB,
	input wire logic [7:0] O_DATA,
	input wire logic O_READY
);
	wire cmd = wr_stb && !register_select;
	wire psv = cmd && wr_data[7:4] == 4'h4;
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (chip_reset_in);
	contrast_load_a: assert property (cmd && wr_data[7:4] == 4'h7 && !O_SLEEP |=>
		O_CONTRAST == $past(wr_data[3:0])) else $error("contrast not loaded");
	reset_flags_a: assert property (disable iff (1'b0) chip_reset_in |->
		O_CONTRAST == 4'h0 && !O_OSC_ON && !O_DISPLAY_ON && !O_REGULATOR_ENABLE
		&& !O_FOLLOWER_ENABLE && !O_BOOST_ENABLE) else $error("reset state wrong");
	power_ctrl_a: assert property (cmd && wr_data[7:3] == 5'h0A && !O_SLEEP |=>
		O_REGULATOR_ENABLE == $past(wr_data[2]) && O_FOLLOWER_ENABLE == $past(wr_data[1]))
		else $error("power control not taken");
	boost_osc_a: assert property (O_BOOST_ENABLE |-> O_OSC_ON)
		else $error("boost without oscillator");
	sleep_entry_a: assert property ($rose(O_SLEEP) |-> !O_REGULATOR_ENABLE
		&& !O_FOLLOWER_ENABLE && !O_BOOST_ENABLE && !O_OSC_ON) else $error("bad sleep entry");
	sleep_drive_a: assert property (##1 O_COMMON_DRIVE_HIGH == $past(O_SLEEP))
		else $error("drive level not following sleep");
	sleep_hold_a: assert property (O_SLEEP && !psv |=>
		$stable(O_CONTRAST) && $stable(O_DISPLAY_ON)) else $error("state changed in sleep");
	wake_up_a: assert property (O_SLEEP && psv && !wr_data[3] && !wr_data[0] |=>
		!O_SLEEP && O_OSC_ON == $past(wr_data[1])) else $error("no wake");
	ready_time_a: assert property ($fell(chip_reset_in) |-> ##[1:20] O_READY)
		else $error("ready late");
	data_pass_a: assert property (wr_stb && register_select && !O_SLEEP |=>
		O_DATA_STB && O_DATA == $past(wr_data)) else $error("data byte lost");
endmodule

// ===== sim/tb_top.sv
// self-checking bench joining host and device ends
`timescale 1ns/100ps
module tb_top;
	logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, gl = 0;
	logic [3:0] aw = 0, ar = 0;
	logic [31:0] wd = 0, rdata;
	logic awr, wr_, bv, arr, rv, re, fe, be, osc, psf, slp, don, cur, blk, dc, ug, cdh, sdh;
	logic dstb, rdy;
	logic [1:0] br, rr;
	logic [3:0] c;
	logic [7:0] dat, v;
	logic [33:0] q[$];
	int checked = 0, bad_count = 0, i;
	wire [14:0] st = {c, re, fe, be, osc, psf, slp, don, cur, blk, dc, ug};
	lpm_link_if lk();
	always #25 clk = ~clk;
	lpm_host lpm_host_inst (.I_REF_CLK(clk), .I_RST(rst), .link(lk), .i_awaddr(aw),
		.i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv),
		.o_wready(wr_), .o_bresp(br), .o_bvalid(bv), .i_bready(bre), .i_araddr(ar),
		.i_arvalid(arv), .o_arready(arr), .o_rdata(rdata), .o_rresp(rr), .o_rvalid(rv),
		.i_rready(rre));
	lpm_device lpm_device_inst (.I_REF_CLK(clk), .link(lk), .i_glyph_use_req(gl),
		.O_CONTRAST(c), .O_REGULATOR_ENABLE(re), .O_FOLLOWER_ENABLE(fe), .O_BOOST_ENABLE(be),
		.O_OSC_ON(osc), .O_POWER_SAVE_FLAG(psf), .O_SLEEP(slp), .O_DISPLAY_ON(don),
		.O_CURSOR_SHOW(cur), .O_BLINK(blk), .O_DUAL_CURSOR(dc), .O_USER_GLYPH_RAM_USE(ug),
		.O_COMMON_DRIVE_HIGH(cdh), .O_SEGMENT_DRIVE_HIGH(sdh), .O_DATA_STB(dstb),
		.O_DATA(dat), .O_READY(rdy));
	lpm_chk lpm_chk_inst (.I_REF_CLK(clk), .chip_reset_in(lk.chip_reset_in),
		.wr_stb(lk.wr_stb), .register_select(lk.register_select), .wr_data(lk.wr_data),
		.O_CONTRAST(c), .O_REGULATOR_ENABLE(re), .O_FOLLOWER_ENABLE(fe),
		.O_BOOST_ENABLE(be), .O_OSC_ON(osc), .O_SLEEP(slp), .O_DISPLAY_ON(don),
		.O_COMMON_DRIVE_HIGH(cdh), .O_DATA_STB(dstb), .O_DATA(dat), .O_READY(rdy));
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic end_sim;
		$display("checked %0d bad %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// axi write, expected response and optional data byte noted first
	task automatic axw(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e,
		input logic isd);
		q.push_back({e, 32'h0});
		if (isd) q.push_back({26'h0, d});
		@(posedge clk);
		aw <= a;
		wd <= {24'h0, d};
		awv <= 1;
		wv <= 1;
		bre <= 1;
		do begin
			@(posedge clk);
			if (awr) awv <= 0;
			if (wr_) wv <= 0;
		end while (awv || wv || !bv);
		bre <= 0;
	endtask
	task automatic axr(input logic [3:0] a, input logic [33:0] e);
		q.push_back(e);
		@(posedge clk);
		ar <= a;
		arv <= 1;
		rre <= 1;
		do begin
			@(posedge clk);
			if (arr) arv <= 0;
		end while (arv || !rv);
		rre <= 0;
	endtask
	task automatic cm(input logic [7:0] d);
		axw(lpm_pkg::LPM_A_CMD, d, lpm_pkg::LPM_RESP_OK, 1'b0);
		repeat (4) @(posedge clk);
	endtask
	task automatic ck(input logic [14:0] e);
		chk({19'h0, st}, {19'h0, e});
	endtask
	task automatic up;
		while (lk.chip_reset_in !== 1'b0) @(posedge clk);
		repeat (19) @(posedge clk);
		chk({33'h0, rdy}, 34'h0);
		@(posedge clk);
		chk({33'h0, rdy}, 34'h1);
	endtask
	always @(posedge clk) begin
		if (bv && bre) chk({br, 32'h0}, q.pop_front());
		if (rv && rre) chk({rr, rdata}, q.pop_front());
		if (dstb) chk({26'h0, dat}, q.pop_front());
	end
	initial begin
		#200000;
		bad_count++;
		end_sim();
	end
	initial begin
		i = $urandom(32'h5389526e);
		repeat (20) @(posedge clk);
		rst <= 0;
		up();
		ck(15'h0000);
		axr(lpm_pkg::LPM_A_STAT, {lpm_pkg::LPM_RESP_OK, 32'h0});
		for (i = 0; i < 16; i++) begin
			cm(8'h70 | i[7:0]);
			ck({i[3:0], 11'h0});
		end
		cm(8'h70);
		cm(8'h57);
		ck(15'h0600);
		cm(8'h42);
		cm(8'h57);
		ck(15'h0780);
		cm(8'h3F);
		cm(8'h78);
		ck(15'h479E);
		cm(8'h43);
		ck(15'h47DE);
		cm(8'h50);
		cm(8'h41);
		ck(15'h407E);
		chk({32'h0, cdh, sdh}, 34'h3);
		cm(8'h7F);
		ck(15'h407E);
		cm(8'h42);
		ck(15'h409E);
		v = 8'($urandom);
		axw(lpm_pkg::LPM_A_DATA, v, lpm_pkg::LPM_RESP_OK, 1'b1);
		axw(lpm_pkg::LPM_A_STAT, 8'h00, lpm_pkg::LPM_RESP_ERR, 1'b0);
		axr(lpm_pkg::LPM_A_CMD, {lpm_pkg::LPM_RESP_ERR, 32'h0});
		gl <= 1;
		repeat (3) @(posedge clk);
		gl <= 0;
		ck(15'h409F);
		axw(lpm_pkg::LPM_A_LINK, 8'h01, lpm_pkg::LPM_RESP_OK, 1'b0);
		repeat (4) @(posedge clk);
		ck(15'h0000);
		axr(lpm_pkg::LPM_A_LINK, {lpm_pkg::LPM_RESP_OK, 32'h2});
		up();
		ck(15'h0000);
		end_sim();
	end
endmodule
